// file: pmgb_pkg.sv
/*
 pmgb_pkg: constants for the shadow parameter gateway and burn block.
 assumes a 50 MHz core clock and a serial host link sampled on its own link clock.
*/
package pmgb_pkg;
	// register offsets
	localparam logic [7:0] OFS_IRQ_SOURCE = 8'h00;
	localparam logic [7:0] OFS_PARAM_STATUS = 8'h08;
	localparam logic [7:0] OFS_OPMODE = 8'h09;
	localparam logic [7:0] OFS_GW_CONFIG = 8'h0d;
	localparam logic [7:0] OFS_BURST_BASE = 8'h0e;
	localparam logic [7:0] OFS_KEY_HIGH = 8'hac;
	localparam logic [7:0] OFS_KEY_LOW = 8'had;
	// burn unlock values
	localparam logic [7:0] KEY_HIGH_VAL = 8'h62;
	localparam logic [7:0] KEY_LOW_VAL = 8'h9d;
	localparam logic [7:0] CONFIRM1_VAL = 8'ha5;
	localparam logic [7:0] CONFIRM2_VAL = 8'h5a;
	// field positions and codes
	localparam int GW_FIELD_LSB = 3;
	localparam logic [1:0] GW_EN_ON = 2'b01;
	localparam logic [2:0] GW_CFG_RST = 3'h0;
	localparam logic [7:0] BASE_RST = 8'h00;
	localparam logic [7:0] BASE_MAX = 8'h78;
	localparam int IRQ_WRITE_BIT = 5;
	localparam int IRQ_BURN_BIT = 6;
	localparam int STAT_VALID_BIT = 3;
	localparam logic [1:0] MODE_ACTIVE = 2'b00;
	localparam logic [1:0] MODE_DOZE = 2'b01;
	localparam logic [1:0] MODE_SLEEP = 2'b10;
	localparam logic [2:0] MAX_BURNS = 3'h3;
	localparam logic [2:0] COUNT_EXHAUSTED = 3'h4;
	localparam int BURST_LEN = 8;
	localparam int PMEM_DEPTH = 128;
	// timing
	localparam int CLK_HZ = 50_000_000;
	localparam int SLEEP_APPLY_MS = 30;
	localparam int SLEEP_APPLY_CYC = (CLK_HZ / 1000) * SLEEP_APPLY_MS;
	localparam int BURN_TIME_US = 1000;
	localparam int BURN_CYC = (CLK_HZ / 1_000_000) * BURN_TIME_US;
	// link slave address, value arbitrary
	localparam logic [6:0] LINK_SLAVE_ADDR = 7'h2b;
	typedef enum logic [1:0] {PMGB_REQ_WR, PMGB_REQ_RD, PMGB_REQ_STOP} pmgb_req_t;
	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_REG, L_WDATA, L_RDATA} pmgb_lstate_t;
	// factory default parameter contents, values arbitrary
	function automatic logic [7:0] factory_default(input int idx);
		factory_default = 8'(idx) ^ 8'ha0;
	endfunction
endpackage

// file: pmgb_gateway.sv
/*
 pmgb_gateway: host gateway to the shadow parameter memory, burst staging,
 nonvolatile burn with burn counter, and the serial slave that carries register access.
 assumes scl/sda arrive from the host on pins; link_clk samples them and is unrelated to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module pmgb_gateway
	import pmgb_pkg::*;
#(
	parameter int SLEEP_CYC = SLEEP_APPLY_CYC,
	parameter int BURN_CYCLES = BURN_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_n,
	input wire logic nvm_factory_clr,
	output logic host_irq_n,
	output logic [1:0] op_mode
);
	// ---------------- link domain ----------------
	logic lrst_m_q, lrst_q;
	logic scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
	pmgb_lstate_t lst_q, lst_d;
	logic [3:0] bitcnt_q, bitcnt_d;
	logic [7:0] shift_q, shift_d, ptr_q, ptr_d;
	logic drive_q, drive_d, lreq_tgl_q, lreq_tgl_d;
	logic [7:0] lreq_addr_q, lreq_addr_d, lreq_data_q, lreq_data_d;
	pmgb_req_t lreq_kind_q, lreq_kind_d;
	logic l_start, l_stop, l_rise, l_fall;
	logic [7:0] rdata_q, rdata_d;

	always_ff @(posedge link_clk) begin
		lrst_m_q <= srst;
		lrst_q <= lrst_m_q;
		scl_m_q <= scl;
		scl_s_q <= scl_m_q;
		scl_p_q <= scl_s_q;
		sda_m_q <= sda_in;
		sda_s_q <= sda_m_q;
		sda_p_q <= sda_s_q;
	end

	assign l_start = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
	assign l_stop = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
	assign l_rise = scl_s_q & ~scl_p_q;
	assign l_fall = ~scl_s_q & scl_p_q;

	always_comb begin
		lst_d = lst_q;
		bitcnt_d = bitcnt_q;
		shift_d = shift_q;
		ptr_d = ptr_q;
		drive_d = drive_q;
		lreq_tgl_d = lreq_tgl_q;
		lreq_addr_d = lreq_addr_q;
		lreq_data_d = lreq_data_q;
		lreq_kind_d = lreq_kind_q;
		if (l_start) begin
			lst_d = L_ADDR;
			// the start's own scl fall wraps the count to zero
			bitcnt_d = 4'hf;
			drive_d = 1'b0;
		end else if (l_stop) begin
			lst_d = L_IDLE;
			drive_d = 1'b0;
			lreq_tgl_d = ~lreq_tgl_q;
			lreq_kind_d = PMGB_REQ_STOP;
		end else if (lst_q != L_IDLE && l_rise) begin
			if (bitcnt_q < 4'h8) begin
				shift_d = {shift_q[6:0], sda_s_q};
			end else if (lst_q == L_RDATA) begin
				if (sda_s_q) begin
					lst_d = L_IDLE;
				end else begin
					lreq_tgl_d = ~lreq_tgl_q;
					lreq_kind_d = PMGB_REQ_RD;
					lreq_addr_d = ptr_q;
				end
			end
		end else if (lst_q != L_IDLE && l_fall) begin
			if (bitcnt_q == 4'h7) begin
				bitcnt_d = 4'h8;
				drive_d = 1'b0;
				unique case (lst_q)
					L_ADDR: begin
						if (shift_q[7:1] == LINK_SLAVE_ADDR) begin
							drive_d = 1'b1;
							if (shift_q[0]) begin
								lreq_tgl_d = ~lreq_tgl_q;
								lreq_kind_d = PMGB_REQ_RD;
								lreq_addr_d = ptr_q;
							end
						end else begin
							lst_d = L_IDLE;
						end
					end
					L_REG: begin
						drive_d = 1'b1;
						ptr_d = shift_q;
					end
					L_WDATA: begin
						drive_d = 1'b1;
						lreq_tgl_d = ~lreq_tgl_q;
						lreq_kind_d = PMGB_REQ_WR;
						lreq_addr_d = ptr_q;
						lreq_data_d = shift_q;
						ptr_d = ptr_q + 8'h01;
					end
					L_RDATA: ptr_d = ptr_q + 8'h01;
					default: lst_d = L_IDLE;
				endcase
			end else if (bitcnt_q == 4'h8) begin
				bitcnt_d = 4'h0;
				drive_d = 1'b0;
				unique case (lst_q)
					L_ADDR: lst_d = shift_q[0] ? L_RDATA : L_REG;
					L_REG: lst_d = L_WDATA;
					default: lst_d = lst_q;
				endcase
				if (lst_q == L_RDATA || (lst_q == L_ADDR && shift_q[0])) begin
					shift_d = rdata_q;
					drive_d = ~rdata_q[7];
				end
			end else begin
				bitcnt_d = bitcnt_q + 4'h1;
				if (lst_q == L_RDATA) begin
					drive_d = ~shift_q[7];
				end
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (lrst_q) begin
			lst_q <= L_IDLE;
			bitcnt_q <= 4'h0;
			shift_q <= 8'h00;
			ptr_q <= 8'h00;
			drive_q <= 1'b0;
			lreq_tgl_q <= 1'b0;
			lreq_addr_q <= 8'h00;
			lreq_data_q <= 8'h00;
			lreq_kind_q <= PMGB_REQ_STOP;
		end else begin
			lst_q <= lst_d;
			bitcnt_q <= bitcnt_d;
			shift_q <= shift_d;
			ptr_q <= ptr_d;
			drive_q <= drive_d;
			lreq_tgl_q <= lreq_tgl_d;
			lreq_addr_q <= lreq_addr_d;
			lreq_data_q <= lreq_data_d;
			lreq_kind_q <= lreq_kind_d;
		end
	end

	// open-drain: only ever drives low
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drive_q;

	// ---------------- core domain ----------------
	logic req_m_q, req_s_q, req_p_q, req_ev;
	logic [2:0] cfg_q, cfg_d;
	logic [7:0] base_q, base_d;
	logic [1:0] mode_q, mode_d, irq_q, irq_d;
	logic [7:0] stage_q [BURST_LEN], stage_d [BURST_LEN];
	logic [7:0] mask_q, mask_d;
	logic [2:0] seq_q, seq_d, count_q, count_d;
	logic valid_q, valid_d, pend_q, pend_d, burn_q, burn_d, reload_q, irq_n_q;
	logic [7:0] pend_base_q, pend_base_d;
	logic [20:0] wait_q, wait_d;
	logic [7:0] shadow_q [PMEM_DEPTH], shadow_d [PMEM_DEPTH];
	logic [7:0] nvm_q [PMEM_DEPTH], nvm_d [PMEM_DEPTH];
	logic gw_on, is_wr, is_rd;
	logic [7:0] a;

	always_ff @(posedge clk) begin
		req_m_q <= lreq_tgl_q;
		req_s_q <= req_m_q;
		req_p_q <= req_s_q;
	end

	assign req_ev = req_s_q ^ req_p_q;
	assign a = lreq_addr_q;
	assign is_wr = req_ev && lreq_kind_q == PMGB_REQ_WR;
	assign is_rd = req_ev && lreq_kind_q == PMGB_REQ_RD;
	// only code 01 opens the gateway
	assign gw_on = cfg_q[2:1] == GW_EN_ON;

	always_comb begin
		cfg_d = cfg_q;
		base_d = base_q;
		mode_d = mode_q;
		irq_d = irq_q;
		stage_d = stage_q;
		mask_d = mask_q;
		seq_d = seq_q;
		count_d = count_q;
		valid_d = valid_q;
		pend_d = pend_q;
		pend_base_d = pend_base_q;
		wait_d = wait_q;
		burn_d = burn_q;
		rdata_d = rdata_q;
		shadow_d = shadow_q;
		nvm_d = nvm_q;
		// reload burned or factory contents after reset
		if (reload_q) begin
			for (int i = 0; i < PMEM_DEPTH; i++) begin
				shadow_d[i] = valid_q ? nvm_q[i] : factory_default(i);
			end
		end
		// source read clears bits, set below wins
		if (is_rd && !(gw_on && a < 8'(BURST_LEN)) && a == OFS_IRQ_SOURCE) begin
			irq_d = 2'b00;
		end
		if (is_rd) begin
			rdata_d = 8'h00;
			// gateway read maps 0..7 onto the burst in any mode
			if (gw_on && a < 8'(BURST_LEN)) begin
				rdata_d = cfg_q[0] ? shadow_q[{base_q[6:3], a[2:0]}] : stage_q[a[2:0]];
			end else begin
				unique case (a)
					OFS_IRQ_SOURCE: rdata_d = {1'b0, irq_q[1], irq_q[0], 5'h00};
					OFS_PARAM_STATUS: rdata_d = {4'h0, valid_q, count_q};
					OFS_OPMODE: rdata_d = {6'h00, mode_q};
					OFS_GW_CONFIG: rdata_d = {2'b00, cfg_q, 3'b000};
					OFS_BURST_BASE: rdata_d = base_q;
					default: rdata_d = 8'h00;
				endcase
			end
		end
		if (is_wr) begin
			// any other write breaks the unlock
			seq_d = 3'h0;
			// gateway write stages one byte of the burst in any mode
			if (gw_on && a < 8'(BURST_LEN)) begin
				if (!cfg_q[0]) begin
					stage_d[a[2:0]] = lreq_data_q;
					mask_d[a[2:0]] = 1'b1;
				end
			end else begin
				unique case (a)
					OFS_OPMODE: begin
						if (lreq_data_q[1:0] != 2'b11) begin
							mode_d = lreq_data_q[1:0];
						end
					end
					OFS_GW_CONFIG: begin
						cfg_d = lreq_data_q[5:3];
						mask_d = 8'h00;
						// complete burst is queued on terminate
						if (gw_on && !cfg_q[0] && lreq_data_q[5:3] == 3'b000 && &mask_q) begin
							pend_d = 1'b1;
							pend_base_d = base_q;
							wait_d = mode_q == MODE_SLEEP ? 21'(SLEEP_CYC - 1) : 21'h0;
						end
					end
					OFS_BURST_BASE: begin
						if (seq_q == 3'h2 && lreq_data_q == CONFIRM1_VAL) begin
							seq_d = 3'h3;
						end else if (seq_q == 3'h3 && lreq_data_q == CONFIRM2_VAL) begin
							seq_d = 3'h4;
						end else if (lreq_data_q <= BASE_MAX) begin
							base_d = {lreq_data_q[7:3], 3'b000};
						end
					end
					OFS_KEY_HIGH: begin
						if (lreq_data_q == KEY_HIGH_VAL) begin
							seq_d = 3'h1;
						end
					end
					OFS_KEY_LOW: begin
						if (seq_q == 3'h1 && lreq_data_q == KEY_LOW_VAL) begin
							seq_d = 3'h2;
						end
					end
					default: seq_d = 3'h0;
				endcase
			end
		end
		if (req_ev && lreq_kind_q == PMGB_REQ_STOP) begin
			seq_d = 3'h0;
			// burn starts only on stop after full sequence
			if (seq_q == 3'h4 && mode_q != MODE_SLEEP && !burn_q) begin
				burn_d = 1'b1;
				wait_d = 21'(BURN_CYCLES - 1);
			end
		end
		if (pend_q && !burn_q) begin
			if (wait_q == 21'h0) begin
				pend_d = 1'b0;
				for (int i = 0; i < BURST_LEN; i++) begin
					shadow_d[{pend_base_q[6:3], 3'(i)}] = stage_q[i];
				end
				// applied burst flags source bit 5 unless in sleep mode
				if (mode_q != MODE_SLEEP) begin
					irq_d[0] = 1'b1;
				end
			end else begin
				wait_d = wait_q - 21'h1;
			end
		end
		if (burn_q) begin
			if (wait_q == 21'h0) begin
				burn_d = 1'b0;
				// finished burn flags source bit 6
				irq_d[1] = 1'b1;
				if (count_q < COUNT_EXHAUSTED) begin
					count_d = count_q + 3'h1;
				end
				if (count_q < MAX_BURNS) begin
					nvm_d = shadow_q;
					valid_d = 1'b1;
				end else begin
					valid_d = 1'b0;
				end
			end else begin
				wait_d = wait_q - 21'h1;
			end
		end
		// factory state: empty memory, zero count
		if (nvm_factory_clr) begin
			count_d = 3'h0;
			valid_d = 1'b0;
			for (int i = 0; i < PMEM_DEPTH; i++) begin
				nvm_d[i] = 8'h00;
			end
		end
	end

	// nonvolatile state survives srst
	always_ff @(posedge clk) begin
		nvm_q <= nvm_d;
		count_q <= count_d;
		valid_q <= valid_d;
		shadow_q <= shadow_d;
		stage_q <= stage_d;
		rdata_q <= rdata_d;
		pend_base_q <= pend_base_d;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			cfg_q <= GW_CFG_RST;
			base_q <= BASE_RST;
			mode_q <= MODE_ACTIVE;
			irq_q <= 2'b00;
			mask_q <= 8'h00;
			seq_q <= 3'h0;
			pend_q <= 1'b0;
			wait_q <= 21'h0;
			burn_q <= 1'b0;
			reload_q <= 1'b1;
			irq_n_q <= 1'b1;
		end else begin
			cfg_q <= cfg_d;
			base_q <= base_d;
			mode_q <= mode_d;
			irq_q <= irq_d;
			mask_q <= mask_d;
			seq_q <= seq_d;
			pend_q <= pend_d;
			wait_q <= wait_d;
			burn_q <= burn_d;
			reload_q <= 1'b0;
			irq_n_q <= ~|irq_d;
		end
	end

	assign host_irq_n = irq_n_q;
	assign op_mode = mode_q;
endmodule // pmgb_gateway
`default_nettype wire

// file: pmgb_gateway_chk_sva.sv
/*
 pmgb_gateway_chk: port-level assertions for the parameter gateway.
 assumes it is bound to pmgb_gateway and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module pmgb_gateway_chk
	import pmgb_pkg::*;
#(
	parameter int SLEEP_CYC = SLEEP_APPLY_CYC,
	parameter int BURN_CYCLES = BURN_CYC
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic scl,
	input wire logic sda_out,
	input wire logic sda_oe_n,
	input wire logic host_irq_n,
	input wire logic [1:0] op_mode
);
	property p_rst_state;
		@(posedge clk) srst |=> host_irq_n && op_mode == MODE_ACTIVE;
	endproperty
	a_rst_state: assert property (p_rst_state) else $error("reset state wrong");
	property p_mode_legal;
		@(posedge clk) disable iff (srst) op_mode != 2'b11;
	endproperty
	a_mode_legal: assert property (p_mode_legal) else $error("reserved mode");
	property p_mode_chg;
		@(posedge clk) disable iff (srst) $changed(op_mode) |-> !scl;
	endproperty
	a_mode_chg: assert property (p_mode_chg) else $error("mode moved off a write");
	property p_irq_sleep;
		@(posedge clk) disable iff (srst) $fell(host_irq_n) |-> $past(op_mode) != MODE_SLEEP;
	endproperty
	a_irq_sleep: assert property (p_irq_sleep) else $error("irq raised in sleep");
	property p_irq_clear;
		@(posedge clk) disable iff (srst) $rose(host_irq_n) |-> !scl;
	endproperty
	a_irq_clear: assert property (p_irq_clear) else $error("irq cleared off a read");
	property p_oe_rst;
		@(posedge link_clk) srst [*5] |-> sda_oe_n;
	endproperty
	a_oe_rst: assert property (p_oe_rst) else $error("sda driven in reset");
	property p_oe_edge;
		@(posedge link_clk) disable iff (srst) $changed(sda_oe_n) |-> !scl;
	endproperty
	a_oe_edge: assert property (p_oe_edge) else $error("sda moved with scl high");
	property p_drive_low;
		@(posedge link_clk) disable iff (srst) scl [*8] |-> sda_oe_n && sda_out == 1'b0;
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("sda held on an idle bus");
	c_irq: cover property (@(posedge clk) $fell(host_irq_n));
	c_sleep: cover property (@(posedge clk) op_mode == MODE_SLEEP);
	c_ack: cover property (@(posedge link_clk) $fell(sda_oe_n));
endmodule // pmgb_gateway_chk
bind pmgb_gateway pmgb_gateway_chk #(.SLEEP_CYC(SLEEP_CYC), .BURN_CYCLES(BURN_CYCLES)) u_chk (
	.clk(clk), .srst(srst), .link_clk(link_clk), .scl(scl), .sda_out(sda_out),
	.sda_oe_n(sda_oe_n), .host_irq_n(host_irq_n), .op_mode(op_mode));
`default_nettype wire

// file: pmgb_host_model.sv
/*
 pmgb_host_model: serial host master driving scl and sharing the sda wire.
 assumes a pull-up on sda; the device pulls low only while sda_oe_n is low.
*/
`timescale 1ns/1ps
`default_nettype none
module pmgb_host_model #(
	parameter int Q = 160
) (
	output logic scl,
	output logic sda_line,
	input wire logic sda_oe_n,
	input wire logic sda_out
);
	logic m_low = 1'b0;
	initial scl = 1'b1;
	// wired pull-downs over the pull-up
	assign sda_line = !(m_low || (!sda_oe_n && !sda_out));
	task automatic bitx(input logic b, output logic r);
		m_low = !b;
		#(Q) scl = 1'b1;
		#(Q) r = sda_line;
		#(Q) scl = 1'b0;
		#(Q);
	endtask
	task automatic start();
		m_low = 1'b0;
		#(Q) scl = 1'b1;
		#(Q) m_low = 1'b1;
		#(Q) scl = 1'b0;
		#(Q);
	endtask
	task automatic stop();
		m_low = 1'b1;
		#(Q) scl = 1'b1;
		#(Q) m_low = 1'b0;
		#(Q);
	endtask
	// bytes go whole, then the ack slot
	task automatic xb(input logic [7:0] b, input logic ak_in, output logic [7:0] r, output logic ak);
		for (int i = 7; i >= 0; i--) begin
			bitx(b[i], r[i]);
		end
		bitx(ak_in, ak);
	endtask
endmodule // pmgb_host_model
`default_nettype wire

// file: test_param_memory_gateway_burn.sv
/*
 test_param_memory_gateway_burn: self-checking bench for pmgb_gateway.
 assumes pmgb_host_model as host and shortened sleep and burn counts.
*/
`timescale 1ns/1ps
`default_nettype none
module test_param_memory_gateway_burn
	import pmgb_pkg::*;
;
	localparam int SLP = 50;
	localparam int BC = 40;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	logic nvm_factory_clr = 1'b1;
	logic scl, sda_line, sda_out, sda_oe_n, host_irq_n;
	logic [1:0] op_mode;
	int n_mismatch = 0;
	int compares = 0;
	int seed = 32'h16c36d12;
	logic [7:0] wd [8];
	logic [7:0] rdat [8];
	logic [7:0] mem [128];
	logic [7:0] b1, b2;
	always #10 clk = ~clk;
	initial begin
		#7;
		forever #24 link_clk = ~link_clk;
	end
	pmgb_gateway #(.SLEEP_CYC(SLP), .BURN_CYCLES(BC)) uut (.clk(clk), .srst(srst),
		.link_clk(link_clk), .scl(scl), .sda_in(sda_line), .sda_out(sda_out),
		.sda_oe_n(sda_oe_n), .nvm_factory_clr(nvm_factory_clr), .host_irq_n(host_irq_n),
		.op_mode(op_mode));
	pmgb_host_model host (.scl(scl), .sda_line(sda_line), .sda_oe_n(sda_oe_n), .sda_out(sda_out));
	function automatic logic [7:0] dflt(input int i);
		return 8'(i) ^ 8'ha0;
	endfunction
	function automatic logic [7:0] exp_stat(input logic [2:0] c);
		return {4'h0, c != 3'h0 && c <= 3'h3, c};
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic close_out();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic pulse_rst();
		@(negedge clk) srst = 1'b1;
		repeat (12) @(negedge clk);
		srst = 1'b0;
		nvm_factory_clr = 1'b0;
		repeat (40) @(negedge clk);
	endtask
	task automatic wait_irq(input int lim, output logic seen);
		seen = 1'b0;
		for (int i = 0; i < lim && !seen; i++) begin
			@(negedge clk);
			seen = (host_irq_n === 1'b0);
		end
	endtask
	task automatic wr(input logic [7:0] ra, input int n, input logic stp);
		logic [7:0] r;
		logic a, bad;
		host.start();
		host.xb({LINK_SLAVE_ADDR, 1'b0}, 1'b1, r, bad);
		host.xb(ra, 1'b1, r, a);
		bad |= a;
		for (int i = 0; i < n; i++) begin
			host.xb(wd[i], 1'b1, r, a);
			bad |= a;
		end
		if (stp) host.stop();
		chk({7'h0, bad}, 8'h00);
	endtask
	task automatic wr1(input logic [7:0] ra, input logic [7:0] d, input logic stp);
		wd[0] = d;
		wr(ra, 1, stp);
	endtask
	task automatic rd(input logic [7:0] ra, input int n);
		logic a;
		wr(ra, 0, 1'b1);
		host.start();
		host.xb({LINK_SLAVE_ADDR, 1'b1}, 1'b1, rdat[0], a);
		for (int i = 0; i < n; i++) begin
			host.xb(8'hff, i == n - 1, rdat[i], a);
		end
		host.stop();
	endtask
	task automatic burst(input logic [1:0] md, input logic [7:0] b);
		logic seen;
		wr1(OFS_OPMODE, {6'h0, md}, 1'b1);
		chk({6'h0, op_mode}, {6'h0, md});
		wr1(OFS_GW_CONFIG, 8'h10, 1'b1);
		wr1(OFS_BURST_BASE, b, 1'b1);
		for (int i = 0; i < 8; i++) begin
			wd[i] = 8'($random(seed));
			mem[b + i] = wd[i];
		end
		wr(8'h00, 8, 1'b1);
		wr1(OFS_GW_CONFIG, 8'h00, 1'b1);
		wait_irq(SLP + 20, seen);
		chk({7'h0, seen}, {7'h0, md != MODE_SLEEP});
		rd(OFS_IRQ_SOURCE, 1);
		chk(rdat[0], md != MODE_SLEEP ? 8'h20 : 8'h00);
		chk({7'h0, host_irq_n}, 8'h01);
	endtask
	task automatic rback(input logic [7:0] b);
		wr1(OFS_GW_CONFIG, 8'h18, 1'b1);
		wr1(OFS_BURST_BASE, b, 1'b1);
		rd(8'h00, 8);
		for (int i = 0; i < 8; i++) begin
			chk(rdat[i], mem[b + i]);
		end
		wr1(OFS_GW_CONFIG, 8'h00, 1'b1);
	endtask
	task automatic burn(input logic [7:0] k, input logic [2:0] cnt, input logic ok);
		logic seen;
		wr1(OFS_KEY_HIGH, KEY_HIGH_VAL, 1'b0);
		wr1(OFS_KEY_LOW, k, 1'b0);
		wr1(OFS_BURST_BASE, CONFIRM1_VAL, 1'b0);
		wr1(OFS_BURST_BASE, CONFIRM2_VAL, 1'b1);
		wait_irq(BC + 40, seen);
		chk({7'h0, seen}, {7'h0, ok});
		rd(OFS_IRQ_SOURCE, 1);
		chk(rdat[0], ok ? 8'h40 : 8'h00);
		rd(OFS_PARAM_STATUS, 1);
		chk(rdat[0], exp_stat(cnt));
	endtask
	initial begin
		#1_950_000;
		n_mismatch++;
		close_out();
	end
	initial begin
		logic [7:0] r;
		logic a;
		for (int i = 0; i < 128; i++) begin
			mem[i] = dflt(i);
		end
		b1 = 8'($random(seed)) & 8'h70;
		b2 = 8'($random(seed)) & 8'h78;
		pulse_rst();
		rd(OFS_BURST_BASE, 1);
		chk(rdat[0], BASE_RST);
		rd(OFS_OPMODE, 1);
		chk(rdat[0], 8'h00);
		rd(OFS_PARAM_STATUS, 1);
		chk(rdat[0], exp_stat(3'h0));
		rd(OFS_GW_CONFIG, 1);
		chk(rdat[0], 8'h00);
		host.start();
		host.xb({LINK_SLAVE_ADDR ^ 7'h01, 1'b0}, 1'b1, r, a);
		host.stop();
		chk({7'h0, a}, 8'h01);
		wr1(OFS_BURST_BASE, 8'h80, 1'b1);
		rd(OFS_BURST_BASE, 1);
		chk(rdat[0], 8'h00);
		wr1(OFS_BURST_BASE, 8'h0f, 1'b1);
		rd(OFS_BURST_BASE, 1);
		chk(rdat[0], 8'h08);
		$display("done: reset values");
		burst(MODE_ACTIVE, b1);
		rback(b1);
		burst(MODE_SLEEP, b2);
		rback(b2);
		$display("done: bursts");
		wr1(OFS_OPMODE, {6'h0, MODE_DOZE}, 1'b1);
		wr1(OFS_BURST_BASE, BASE_MAX, 1'b1);
		wr1(OFS_GW_CONFIG, 8'h28, 1'b1);
		rd(OFS_IRQ_SOURCE, 1);
		chk(rdat[0], 8'h00);
		wr1(OFS_GW_CONFIG, 8'h00, 1'b1);
		burn(8'h9c, 3'h0, 1'b0);
		burn(KEY_LOW_VAL, 3'h1, 1'b1);
		pulse_rst();
		rback(b2);
		burn(KEY_LOW_VAL, 3'h2, 1'b1);
		burn(KEY_LOW_VAL, 3'h3, 1'b1);
		burn(KEY_LOW_VAL, 3'h4, 1'b1);
		pulse_rst();
		for (int i = 0; i < 8; i++) begin
			mem[b2 + i] = dflt(b2 + i);
		end
		rback(b2);
		$display("done: burns");
		close_out();
	end
endmodule // test_param_memory_gateway_burn
`default_nettype wire
